// ### obt_regs.vh
`ifndef OBT_REGS_VH
`define OBT_REGS_VH

// Register byte offsets
`define OBT_CTRL_ADDR 8'h00
`define OBT_STATUS_ADDR 8'h04
`define OBT_EVENT_ADDR 8'h08
`define OBT_LOG_ADDR 8'h0c

// Control register fields and reset
`define OBT_CTRL_DRIVE_BIT 0
`define OBT_CTRL_LOG_BIT 1
`define OBT_CTRL_RESET 2'h3

// Status register field positions
`define OBT_STAT_FWD_LSB 0
`define OBT_STAT_REV_LSB 8
`define OBT_STAT_OE_BIT 16
`define OBT_STAT_DIR_BIT 17
`define OBT_STAT_EMPTY_BIT 18

// Event register field
`define OBT_EVENT_OVF_BIT 0

// Log entry layout
`define OBT_LOG_VALID_BIT 31
`define OBT_LOG_WAY_BIT 8

// Data widths and log depth
`define OBT_PORT_W 8
`define OBT_LOG_W 9
`define OBT_LOG_DEPTH 4
`define OBT_LOG_PTR_W 2

// Bus answers
`define OBT_RESP_OKAY 2'h0
`define OBT_RESP_SLVERR 2'h2

`endif

// ### obt_fifo.v
`include "obt_regs.vh"

module obt_fifo #(
   parameter WIDTH = `OBT_LOG_W,
   parameter DEPTH = `OBT_LOG_DEPTH,
   parameter PTR_W = `OBT_LOG_PTR_W
) (
   input wire clk_in,
   input wire srst_in,
   input wire in_valid_in,
   input wire [WIDTH-1:0] in_data_in,
   output wire in_ready_out,
   output wire out_valid_out,
   output wire [WIDTH-1:0] out_data_out,
   input wire out_ready_in
);
   localparam integer DEPTH_M1 = DEPTH - 1;
   localparam [PTR_W:0] FULL_CNT = DEPTH[PTR_W:0];
   localparam [PTR_W-1:0] LAST_PTR = DEPTH_M1[PTR_W-1:0];

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [PTR_W-1:0] wr_ptr;
   reg [PTR_W-1:0] rd_ptr;
   reg [PTR_W:0] count;
   wire push;
   wire pop;

   // Handshake terms
   assign in_ready_out = (count != FULL_CNT);
   assign out_valid_out = (count != {(PTR_W+1){1'b0}});
   assign out_data_out = mem[rd_ptr];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   // Storage write
   always @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   // Pointers and fill count
   always @(posedge clk_in) begin
      if (srst_in) begin
         wr_ptr <= {PTR_W{1'b0}};
         rd_ptr <= {PTR_W{1'b0}};
         count <= {(PTR_W+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == LAST_PTR) ? {PTR_W{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == LAST_PTR) ? {PTR_W{1'b0}} : rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// ### obt_transceiver.v
// The register addresses and the AXI4-Lite register port were left to the implementer.
`include "obt_regs.vh"

module obt_transceiver (
   input wire core_clk_in,
   input wire srst_in,
   input wire [7:0] left_port_in,
   output reg [7:0] left_port_out,
   output reg left_port_oe_out,
   input wire [7:0] right_port_in,
   output reg [7:0] right_port_out,
   output reg right_port_oe_out,
   input wire a_to_b_store_clk_in,
   input wire b_to_a_store_clk_in,
   input wire output_enable_n_in,
   input wire transfer_way_in,
   input wire a_to_b_source_sel_in,
   input wire b_to_a_source_sel_in,
   output reg log_ready_out,
   input wire [7:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output reg s_axi_awready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output reg s_axi_wready_out,
   output reg [1:0] s_axi_bresp_out,
   output reg s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire [7:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output reg s_axi_arready_out,
   output reg [31:0] s_axi_rdata_out,
   output reg [1:0] s_axi_rresp_out,
   output reg s_axi_rvalid_out,
   input wire s_axi_rready_in
);
   // Pin synchronisers, first and second stage
   reg [7:0] left_s1;
   reg [7:0] left_s2;
   reg [7:0] right_s1;
   reg [7:0] right_s2;
   reg [5:0] ctl_s1;
   reg [5:0] ctl_s2;
   reg [1:0] store_clk_d;

   // Stored data and software state
   reg [7:0] fwd_reg;
   reg [7:0] rev_reg;
   reg [1:0] ctrl;
   reg log_ovf;

   // Bus slave state
   reg aw_held;
   reg w_held;
   reg [7:0] wr_addr;
   reg [31:0] wr_data;
   reg [3:0] wr_strb;

   wire sync_fwd_clk;
   wire sync_rev_clk;
   wire sync_oe_n;
   wire sync_way;
   wire sync_a_to_b_sel;
   wire sync_b_to_a_sel;
   wire fwd_rise;
   wire rev_rise;
   wire drive_allow;
   wire log_enable;
   reg next_left_oe;
   reg next_right_oe;
   reg [7:0] next_left_data;
   reg [7:0] next_right_data;

   wire log_in_valid;
   wire [8:0] log_in_data;
   wire log_in_ready;
   wire log_out_valid;
   wire [8:0] log_out_data;
   wire log_pop;
   wire log_lost;
   wire wr_commit;
   wire ar_take;
   reg [31:0] next_rdata;
   reg [1:0] next_rresp;

   // Control pin order within the synchroniser vector
   assign sync_fwd_clk = ctl_s2[0];
   assign sync_rev_clk = ctl_s2[1];
   assign sync_oe_n = ctl_s2[2];
   assign sync_way = ctl_s2[3];
   assign sync_a_to_b_sel = ctl_s2[4];
   assign sync_b_to_a_sel = ctl_s2[5];
   assign drive_allow = ctrl[`OBT_CTRL_DRIVE_BIT];
   assign log_enable = ctrl[`OBT_CTRL_LOG_BIT];

   // Two-flop synchronisers for every pin input
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         left_s1 <= 8'h00;
         left_s2 <= 8'h00;
         right_s1 <= 8'h00;
         right_s2 <= 8'h00;
         ctl_s1 <= 6'h04;
         ctl_s2 <= 6'h04;
         store_clk_d <= 2'h0;
      end else begin
         left_s1 <= left_port_in;
         left_s2 <= left_s1;
         right_s1 <= right_port_in;
         right_s2 <= right_s1;
         ctl_s1 <= {b_to_a_source_sel_in, a_to_b_source_sel_in, transfer_way_in,
                    output_enable_n_in, b_to_a_store_clk_in, a_to_b_store_clk_in};
         ctl_s2 <= ctl_s1;
         store_clk_d <= {sync_rev_clk, sync_fwd_clk};
      end
   end

   // Rising edges of the store clocks
   assign fwd_rise = sync_fwd_clk & ~store_clk_d[0];
   assign rev_rise = sync_rev_clk & ~store_clk_d[1];

   // Storage registers, captured whatever the drive state
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         fwd_reg <= 8'h00;
         rev_reg <= 8'h00;
      end else begin
         if (fwd_rise) begin
            fwd_reg <= left_s2;
         end
         if (rev_rise) begin
            rev_reg <= right_s2;
         end
      end
   end

   // Drive decision: enables are exclusive by construction
   always @* begin
      next_left_oe = drive_allow & ~sync_oe_n & ~sync_way;
      next_right_oe = drive_allow & ~sync_oe_n & sync_way;
      next_left_data = sync_b_to_a_sel ? rev_reg : right_s2;
      next_right_data = sync_a_to_b_sel ? fwd_reg : left_s2;
   end

   // Port output flops
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         left_port_oe_out <= 1'b0;
         right_port_oe_out <= 1'b0;
         left_port_out <= 8'h00;
         right_port_out <= 8'h00;
      end else begin
         left_port_oe_out <= next_left_oe;
         right_port_oe_out <= next_right_oe;
         left_port_out <= next_left_data;
         right_port_out <= next_right_data;
      end
   end

   // Capture log: forward wins when both edges share a cycle
   assign log_in_valid = log_enable & (fwd_rise | rev_rise);
   assign log_in_data = fwd_rise ? {1'b0, left_s2} : {1'b1, right_s2};
   assign log_lost = log_enable & ((fwd_rise & rev_rise) | (log_in_valid & ~log_in_ready));
   assign log_pop = ar_take & (s_axi_araddr_in == `OBT_LOG_ADDR);

   obt_fifo #(
      .WIDTH(`OBT_LOG_W),
      .DEPTH(`OBT_LOG_DEPTH),
      .PTR_W(`OBT_LOG_PTR_W)
   ) u_log (
      .clk_in(core_clk_in),
      .srst_in(srst_in),
      .in_valid_in(log_in_valid),
      .in_data_in(log_in_data),
      .in_ready_out(log_in_ready),
      .out_valid_out(log_out_valid),
      .out_data_out(log_out_data),
      .out_ready_in(log_pop)
   );

   // Write address and data channels, either order
   assign wr_commit = aw_held & w_held & ~s_axi_bvalid_out;
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `OBT_RESP_OKAY;
         wr_addr <= 8'h00;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
      end else begin
         if (s_axi_awready_out & s_axi_awvalid_in) begin
            wr_addr <= s_axi_awaddr_in;
            aw_held <= 1'b1;
            s_axi_awready_out <= 1'b0;
         end else if (~aw_held & ~s_axi_bvalid_out & ~wr_commit) begin
            s_axi_awready_out <= 1'b1;
         end
         if (s_axi_wready_out & s_axi_wvalid_in) begin
            wr_data <= s_axi_wdata_in;
            wr_strb <= s_axi_wstrb_in;
            w_held <= 1'b1;
            s_axi_wready_out <= 1'b0;
         end else if (~w_held & ~s_axi_bvalid_out & ~wr_commit) begin
            s_axi_wready_out <= 1'b1;
         end
         if (wr_commit) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            case (wr_addr)
               `OBT_CTRL_ADDR,
               `OBT_STATUS_ADDR,
               `OBT_EVENT_ADDR,
               `OBT_LOG_ADDR: s_axi_bresp_out <= `OBT_RESP_OKAY;
               default: s_axi_bresp_out <= `OBT_RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid_out & s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // Control register and lost-capture flag, set beats clear
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         ctrl <= `OBT_CTRL_RESET;
         log_ovf <= 1'b0;
         log_ready_out <= 1'b0;
      end else begin
         log_ready_out <= log_in_ready;
         if (wr_commit & (wr_addr == `OBT_CTRL_ADDR) & wr_strb[0]) begin
            ctrl <= wr_data[1:0];
         end
         if (log_lost) begin
            log_ovf <= 1'b1;
         end else if (wr_commit & (wr_addr == `OBT_EVENT_ADDR) & wr_strb[0] &
                      wr_data[`OBT_EVENT_OVF_BIT]) begin
            log_ovf <= 1'b0;
         end
      end
   end

   // Read data select
   always @* begin
      next_rdata = 32'h00000000;
      next_rresp = `OBT_RESP_OKAY;
      case (s_axi_araddr_in)
         `OBT_CTRL_ADDR: next_rdata[1:0] = ctrl;
         `OBT_STATUS_ADDR: begin
            next_rdata[`OBT_STAT_FWD_LSB+7:`OBT_STAT_FWD_LSB] = fwd_reg;
            next_rdata[`OBT_STAT_REV_LSB+7:`OBT_STAT_REV_LSB] = rev_reg;
            next_rdata[`OBT_STAT_OE_BIT] = left_port_oe_out | right_port_oe_out;
            next_rdata[`OBT_STAT_DIR_BIT] = right_port_oe_out;
            next_rdata[`OBT_STAT_EMPTY_BIT] = ~log_out_valid;
         end
         `OBT_EVENT_ADDR: next_rdata[`OBT_EVENT_OVF_BIT] = log_ovf;
         `OBT_LOG_ADDR: begin
            next_rdata[8:0] = log_out_valid ? log_out_data : 9'h000;
            next_rdata[`OBT_LOG_VALID_BIT] = log_out_valid;
         end
         default: next_rresp = `OBT_RESP_SLVERR;
      endcase
   end

   // Read channel, one outstanding
   assign ar_take = s_axi_arready_out & s_axi_arvalid_in;
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h00000000;
         s_axi_rresp_out <= `OBT_RESP_OKAY;
      end else begin
         if (ar_take) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= next_rdata;
            s_axi_rresp_out <= next_rresp;
         end else begin
            if (s_axi_rvalid_out & s_axi_rready_in) begin
               s_axi_rvalid_out <= 1'b0;
            end
            if (~s_axi_rvalid_out) begin
               s_axi_arready_out <= 1'b1;
            end
         end
      end
   end
endmodule

// ### obt_transceiver_assertions.sv
module obt_transceiver_assertions (
   input wire core_clk_in,
   input wire srst_in,
   input wire [7:0] left_port_in,
   input wire [7:0] left_port_out,
   input wire left_port_oe_out,
   input wire [7:0] right_port_in,
   input wire [7:0] right_port_out,
   input wire right_port_oe_out,
   input wire output_enable_n_in,
   input wire transfer_way_in,
   input wire a_to_b_source_sel_in,
   input wire b_to_a_source_sel_in,
   input wire s_axi_arvalid_in,
   input wire s_axi_arready_out,
   input wire s_axi_rvalid_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   // Requested direction, from the pins
   wire drv_l = !output_enable_n_in && !transfer_way_in;
   wire drv_r = !output_enable_n_in && transfer_way_in;
   // Drive ownership
   property p_one_side; !(left_port_oe_out && right_port_oe_out); endproperty
   a_one_side: assert property (p_one_side) else $error("both driven");
   property p_idle;
      output_enable_n_in [*4] |-> !left_port_oe_out && !right_port_oe_out;
   endproperty
   a_idle: assert property (p_idle) else $error("driven while off");
   property p_dir_l; drv_l [*4] |-> !right_port_oe_out; endproperty
   a_dir_l: assert property (p_dir_l) else $error("right driven");
   property p_dir_r; drv_r [*4] |-> !left_port_oe_out; endproperty
   a_dir_r: assert property (p_dir_r) else $error("left driven");
   // Live data paths, settled after the sync latency
   property p_live_l;
      (drv_l && !b_to_a_source_sel_in && $stable(right_port_in)) [*4] ##0 left_port_oe_out
         |-> left_port_out == right_port_in;
   endproperty
   a_live_l: assert property (p_live_l) else $error("left data");
   property p_live_r;
      (drv_r && !a_to_b_source_sel_in && $stable(left_port_in)) [*4] ##0 right_port_oe_out
         |-> right_port_out == left_port_in;
   endproperty
   a_live_r: assert property (p_live_r) else $error("right data");
   // Register bus read timing
   property p_rlat; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
   a_rlat: assert property (p_rlat) else $error("read late");
   property p_ar_block; s_axi_rvalid_out |-> !s_axi_arready_out; endproperty
   a_ar_block: assert property (p_ar_block) else $error("read overlap");
   c_left: cover property (left_port_oe_out);
   c_right: cover property (right_port_oe_out);
   c_read: cover property (s_axi_arvalid_in && s_axi_arready_out);
endmodule

bind obt_transceiver obt_transceiver_assertions chk_i (.*);

// ### obt_bus_model.sv
module obt_bus_model (
   input wire [7:0] left_src_in,
   input wire [7:0] right_src_in,
   input wire [7:0] left_dev_in,
   input wire left_oe_in,
   input wire [7:0] right_dev_in,
   input wire right_oe_in,
   output wire [7:0] left_wire_out,
   output wire [7:0] right_wire_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // Far-side source steps back whenever the device drives
   assign left_wire_out = left_oe_in ? left_dev_in : left_src_in;
   assign right_wire_out = right_oe_in ? right_dev_in : right_src_in;
endmodule

// ### obt_transceiver_tb.sv
`include "obt_regs.vh"

module obt_transceiver_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, srst = 1, fwd_clk = 0, rev_clk = 0, oe_n = 1, way = 0;
   logic fwd_sel = 0, rev_sel = 0;
   logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [7:0] lsrc = 8'h00, rsrc = 8'h00, awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [3:0] ws = 4'hf;
   wire [7:0] lw, rw, lo, ro;
   wire loe, roe, lrdy, awr, wrr, bv, arr, rv;
   wire [1:0] br, rr;
   wire [31:0] rd;
   int n_fail = 0;
   int check_count = 0;

   // Core clock
   always #50 clk = ~clk;

   obt_transceiver dut (.core_clk_in(clk), .srst_in(srst), .left_port_in(lw),
      .left_port_out(lo), .left_port_oe_out(loe), .right_port_in(rw),
      .right_port_out(ro), .right_port_oe_out(roe), .a_to_b_store_clk_in(fwd_clk),
      .b_to_a_store_clk_in(rev_clk), .output_enable_n_in(oe_n), .transfer_way_in(way),
      .a_to_b_source_sel_in(fwd_sel), .b_to_a_source_sel_in(rev_sel), .log_ready_out(lrdy),
      .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wrr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
      .s_axi_bready_in(bry), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
      .s_axi_rvalid_out(rv), .s_axi_rready_in(rry));

   obt_bus_model bus (.left_src_in(lsrc), .right_src_in(rsrc), .left_dev_in(lo),
      .left_oe_in(loe), .right_dev_in(ro), .right_oe_in(roe), .left_wire_out(lw),
      .right_wire_out(rw));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = `OBT_RESP_OKAY);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      repeat (40) begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wrr) wv <= 0;
         if (bv) begin
            bry <= 0;
            chk("bresp", er, br);
            tick(1);
            return;
         end
      end
      chk("write done", 1, 0);
      close_out();
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input logic [1:0] er = `OBT_RESP_OKAY);
      ara <= a;
      arv <= 1;
      rry <= 1;
      repeat (40) begin
         @(posedge clk);
         if (arr) arv <= 0;
         if (rv) begin
            rry <= 0;
            chk("rresp", er, rr);
            chk("rdata", exp, rd);
            tick(1);
            return;
         end
      end
      chk("read done", 1, 0);
      close_out();
   endtask

   task automatic store(input bit rev);
      if (rev) rev_clk <= 1;
      else fwd_clk <= 1;
      tick(3);
      fwd_clk <= 0;
      rev_clk <= 0;
      tick(3);
   endtask

   task automatic pins(input logic o, w, a, b, input int n);
      oe_n <= o;
      way <= w;
      fwd_sel <= a;
      rev_sel <= b;
      tick(n);
   endtask

   task automatic t_live;
      lsrc <= 8'ha5;
      rsrc <= 8'h3c;
      pins(0, 1, 0, 0, 4);
      chk("right out", 8'ha5, ro);
      chk("left oe", 0, loe);
      pins(0, 0, 0, 0, 8);
      chk("left out", 8'h3c, lo);
      chk("right oe", 0, roe);
      pins(1, 0, 0, 0, 4);
      chk("left oe", 0, loe);
   endtask

   task automatic t_store;
      lsrc <= 8'h5a;
      rsrc <= 8'hc3;
      tick(4);
      store(0);
      store(1);
      rd_chk(`OBT_STATUS_ADDR, 32'h0000c35a);
      lsrc <= 8'h00;
      rsrc <= 8'hff;
      pins(0, 1, 1, 1, 6);
      chk("right out", 8'h5a, ro);
      pins(0, 0, 1, 1, 8);
      chk("left out", 8'hc3, lo);
   endtask

   task automatic t_gate;
      lsrc <= 8'h81;
      pins(0, 1, 1, 1, 6);
      store(0);
      chk("right out", 8'h81, ro);
      tick(3);
      store(1);
      pins(0, 0, 1, 1, 8);
      chk("left out", 8'h81, lo);
   endtask

   task automatic t_log;
      chk("log ready", 0, lrdy);
      lsrc <= 8'h11;
      pins(1, 0, 0, 0, 4);
      store(0);
      rd_chk(`OBT_EVENT_ADDR, 32'h1);
      rd_chk(`OBT_STATUS_ADDR, 32'h00008111);
      rd_chk(`OBT_LOG_ADDR, 32'h8000005a);
      rd_chk(`OBT_LOG_ADDR, 32'h800001c3);
      rd_chk(`OBT_LOG_ADDR, 32'h80000081);
      rd_chk(`OBT_LOG_ADDR, 32'h80000181);
      rd_chk(`OBT_LOG_ADDR, 32'h0);
      chk("log ready", 1, lrdy);
      wr(`OBT_EVENT_ADDR, 32'h1);
      rd_chk(`OBT_EVENT_ADDR, 32'h0);
      rd_chk(`OBT_STATUS_ADDR, 32'h00048111);
   endtask

   task automatic t_ctrl;
      pins(0, 1, 0, 0, 4);
      wr(`OBT_CTRL_ADDR, 32'h2);
      tick(4);
      chk("right oe", 0, roe);
      wr(`OBT_CTRL_ADDR, 32'h3);
      tick(4);
      chk("right out", 8'h11, ro);
      chk("right oe", 1, roe);
      chk("left oe", 0, loe);
      rd_chk(`OBT_STATUS_ADDR, 32'h00078111);
      // Unmapped write answers with an error, masked byte write is ignored
      wr(8'h10, 32'h0, `OBT_RESP_SLVERR);
      ws <= 4'he;
      wr(`OBT_CTRL_ADDR, 32'h0);
      ws <= 4'hf;
      rd_chk(`OBT_CTRL_ADDR, 32'h3);
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      srst <= 0;
      tick(1);
      rd_chk(`OBT_CTRL_ADDR, 32'h3);
      rd_chk(8'h10, 32'h0, `OBT_RESP_SLVERR);
      t_live();
      t_store();
      t_gate();
      t_log();
      t_ctrl();
      close_out();
   end
endmodule
